// ---- hdl/csw_clk_div.v ----
/*
 * divider producing one-cycle enable pulses: divide by 2**code for the
 * system clock, or by a prescale count for the pll input.
 * assumes a single clock and active low asynchronous reset.
 */
`timescale 1ns/1ns
`default_nettype none
`include "csw_defines.vh"

module csw_clk_div #(
	parameter W = 4
) (
	input  wire         clk,
	input  wire         rst_n,
	input  wire [W-1:0] period_m1,
	output reg          en_ff
);
	reg [W-1:0] cnt_ff;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= {W{1'b0}};
			en_ff  <= 1'b0;
		end else if (cnt_ff >= period_m1) begin
			cnt_ff <= {W{1'b0}};
			en_ff  <= 1'b1;
		end else begin
			cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
			en_ff  <= 1'b0;
		end
	end
endmodule // csw_clk_div

`default_nettype wire

// ---- hdl/csw_ctrl.v ----
/*
 * oscillator selection and clock switch controller with an ahb-lite
 * register slave, pll lock timing, secondary oscillator enable and
 * clock divider enables.
 * assumes a single 100 MHz clock, ahb-lite master; timer enable and clock
 * fail inputs synchronised here through two flip-flops.
 */
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "csw_defines.vh"

module csw_ctrl #(
	parameter LOCK_CYC = `CSW_LOCK_CYC,
	parameter OST_CYC  = `CSW_OST_CYC
) (
	input  wire        CORE_CLK,
	input  wire        RST_N,
	input  wire        HSEL,
	input  wire [31:0] HADDR,
	input  wire [1:0]  HTRANS,
	input  wire        HWRITE,
	input  wire [2:0]  HSIZE,
	input  wire [31:0] HWDATA,
	input  wire        HREADY,
	output reg  [31:0] HRDATA,
	output reg         HREADYOUT,
	output reg         HRESP,
	input  wire [2:0]  CFG_OSC_SEL,
	input  wire        CFG_SWITCH_ENABLE_N,
	input  wire        CFG_FAIL_SAFE_N,
	input  wire        CFG_WATCHDOG_EN,
	input  wire [2:0]  TIMER_SECONDARY_OSC_ENABLE,
	input  wire        CLOCK_FAIL_EVENT,
	output reg  [7:0]  OSC_ENABLE,
	output reg  [2:0]  SYS_CLK_SEL,
	output reg         SECONDARY_OSC_ON,
	output reg         SWITCH_BUSY,
	output reg         SYSCLK_EN,
	output reg         PLL_IN_EN
);
	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_DONE = 3'b100;

	reg [2:0]  state_ff, nxt_state;
	reg [2:0]  cur_ff, nxt_cur;
	reg [2:0]  next_ff, nxt_next;
	reg [2:0]  tgt_ff, nxt_tgt;
	reg        pend_ff, nxt_pend;
	reg        lock_ff, nxt_lock;
	reg        pll_lock_ff, nxt_pll_lock;
	reg        fail_ff, nxt_fail;
	reg [1:0]  div_ff, nxt_div;
	reg [2:0]  pre_ff, nxt_pre;
	reg        usb_ff, nxt_usb;
	reg [`CSW_CNT_W-1:0] lock_cnt_ff, nxt_lock_cnt;
	reg [`CSW_CNT_W-1:0] ost_cnt_ff, nxt_ost_cnt;
	reg [7:0]  osc_on_ff, nxt_osc_on;
	reg        boot_ff;
	reg [2:0]  tmr_s1_ff, tmr_s2_ff;
	reg        fev_s1_ff, fev_s2_ff;
	reg        ph_wr_ff;
	reg [`CSW_AW-1:0] ph_addr_ff;

	wire sw_en   = ~CFG_SWITCH_ENABLE_N;
	wire low_power_rc_hold = CFG_WATCHDOG_EN | (sw_en & ~CFG_FAIL_SAFE_N);
	wire tmr_hold  = |tmr_s2_ff;
	wire tgt_pll = (tgt_ff == `CSW_SRC_FAST_RC_WITH_PLL) |
		(tgt_ff == `CSW_SRC_PRIPLL);
	wire cur_pll = (cur_ff == `CSW_SRC_FAST_RC_WITH_PLL) |
		(cur_ff == `CSW_SRC_PRIPLL);
	wire tgt_xtal = (tgt_ff == `CSW_SRC_PRI) | (tgt_ff == `CSW_SRC_PRIPLL) |
		(tgt_ff == `CSW_SRC_SEC);
	wire wr_next = ph_wr_ff & (ph_addr_ff == `CSW_ADDR_MAIN);
	wire wr_sec  = ph_wr_ff & (ph_addr_ff == `CSW_ADDR_SECOND);
	wire wr_div  = ph_wr_ff & (ph_addr_ff == `CSW_ADDR_DIV);
	wire addr_ok = (HADDR[`CSW_AW-1:0] == `CSW_ADDR_MAIN) |
		(HADDR[`CSW_AW-1:0] == `CSW_ADDR_SECOND) |
		(HADDR[`CSW_AW-1:0] == `CSW_ADDR_CFG) |
		(HADDR[`CSW_AW-1:0] == `CSW_ADDR_DIV);
	wire take = HSEL & HREADY & HTRANS[1];

	// -----------------------------------------------------------------
	// synchronisers for outside inputs
	// -----------------------------------------------------------------
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tmr_s1_ff <= 3'h0;
			tmr_s2_ff <= 3'h0;
			fev_s1_ff <= 1'b0;
			fev_s2_ff <= 1'b0;
		end else begin
			tmr_s1_ff <= TIMER_SECONDARY_OSC_ENABLE;
			tmr_s2_ff <= tmr_s1_ff;
			fev_s1_ff <= CLOCK_FAIL_EVENT;
			fev_s2_ff <= fev_s1_ff;
		end
	end

	// -----------------------------------------------------------------
	// switch sequencer and registers
	// -----------------------------------------------------------------
	always @* begin
		nxt_state    = state_ff;
		nxt_cur      = cur_ff;
		nxt_next     = next_ff;
		nxt_tgt      = tgt_ff;
		nxt_pend     = pend_ff;
		nxt_lock     = lock_ff;
		nxt_pll_lock = pll_lock_ff;
		nxt_fail     = fail_ff | fev_s2_ff;
		nxt_div      = div_ff;
		nxt_pre      = pre_ff;
		nxt_usb      = usb_ff;
		nxt_lock_cnt = lock_cnt_ff;
		nxt_ost_cnt  = ost_cnt_ff;
		nxt_osc_on   = osc_on_ff;
		if (wr_sec) begin
			nxt_lock = HWDATA[`CSW_LOCK_BIT];
			if (!HWDATA[`CSW_FAIL_BIT] && !fev_s2_ff)
				nxt_fail = 1'b0;
		end
		if (wr_div) begin
			nxt_usb = HWDATA[`CSW_USB_BIT];
			nxt_pre = HWDATA[`CSW_PRE_LSB+2:`CSW_PRE_LSB];
			if (HWDATA[`CSW_DIV_LSB+1:`CSW_DIV_LSB] != `CSW_DIV8_CODE ||
				(cur_pll && !HWDATA[`CSW_USB_BIT]))
				nxt_div = HWDATA[`CSW_DIV_LSB+1:`CSW_DIV_LSB];
		end
		// lock bit never blocks next-source writes, as sw_en needs cfg clear
		if (wr_next && sw_en && !(lock_ff && CFG_SWITCH_ENABLE_N)) begin
			nxt_next = HWDATA[`CSW_NEXT_LSB+2:`CSW_NEXT_LSB];
			nxt_pend = 1'b1;
		end
		if (!cur_pll)
			nxt_pll_lock = 1'b0;
		else if (lock_cnt_ff < LOCK_CYC[`CSW_CNT_W-1:0])
			nxt_lock_cnt = lock_cnt_ff + 16'h0001;
		else
			nxt_pll_lock = 1'b1;
		case (state_ff)
		ST_IDLE: begin
			// evaluated only while idle, with switching allowed or a request pending
			// boot request is still served even with switching disabled
			if ((pend_ff || wr_next) && (sw_en || pend_ff)) begin
				nxt_pend = 1'b0;
				if (nxt_next != cur_ff) begin
					nxt_tgt = nxt_next;
					nxt_state = ST_WAIT;
					nxt_osc_on[nxt_next] = 1'b1;
					nxt_ost_cnt = 16'h0000;
					nxt_lock_cnt = 16'h0000;
					nxt_pll_lock = 1'b0;
				end
			end
		end
		ST_WAIT: begin
			// sequence runs in hardware, cpu not stalled
			if (tgt_xtal && ost_cnt_ff < OST_CYC[`CSW_CNT_W-1:0])
				nxt_ost_cnt = ost_cnt_ff + 16'h0001;
			else if (tgt_pll && lock_cnt_ff < LOCK_CYC[`CSW_CNT_W-1:0])
				nxt_lock_cnt = lock_cnt_ff + 16'h0001;
			else
				nxt_state = ST_DONE;
			if (tgt_pll && lock_cnt_ff >= LOCK_CYC[`CSW_CNT_W-1:0])
				nxt_pll_lock = 1'b1;
		end
		ST_DONE: begin
			nxt_cur = tgt_ff;
			if (tgt_pll)
				nxt_pll_lock = 1'b1;
			nxt_fail = fev_s2_ff;
			if (!tgt_pll && div_ff == `CSW_DIV8_CODE)
				nxt_div = 2'h2;
			// old source off unless still held
			if (!((cur_ff == `CSW_SRC_LOW_POWER_RC) && low_power_rc_hold) &&
				!((cur_ff == `CSW_SRC_SEC) && tmr_hold))
				nxt_osc_on[cur_ff] = 1'b0;
			nxt_osc_on[tgt_ff] = 1'b1;
			nxt_state = ST_IDLE;
		end
		default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff    <= ST_IDLE;
			cur_ff      <= `CSW_SRC_FAST_RC_POSTSCALED;
			next_ff     <= `CSW_SRC_FAST_RC_POSTSCALED;
			tgt_ff      <= `CSW_SRC_FAST_RC_POSTSCALED;
			pend_ff     <= 1'b0;
			lock_ff     <= 1'b0;
			pll_lock_ff <= 1'b0;
			fail_ff     <= 1'b0;
			div_ff      <= 2'h0;
			pre_ff      <= 3'h0;
			usb_ff      <= 1'b0;
			lock_cnt_ff <= 16'h0000;
			ost_cnt_ff  <= 16'h0000;
			osc_on_ff   <= 8'h80;
			boot_ff     <= 1'b1;
		end else if (boot_ff) begin
			// load config source once after release, then switch
			boot_ff  <= 1'b0;
			next_ff  <= CFG_OSC_SEL;
			pend_ff  <= 1'b1;
		end else begin
			state_ff    <= nxt_state;
			cur_ff      <= sw_en ? nxt_cur :
				(nxt_state == ST_IDLE ? nxt_cur : cur_ff);
			next_ff     <= nxt_next;
			tgt_ff      <= nxt_tgt;
			pend_ff     <= nxt_pend;
			lock_ff     <= nxt_lock;
			pll_lock_ff <= nxt_pll_lock;
			fail_ff     <= nxt_fail;
			div_ff      <= nxt_div;
			pre_ff      <= nxt_pre;
			usb_ff      <= nxt_usb;
			lock_cnt_ff <= nxt_lock_cnt;
			ost_cnt_ff  <= nxt_ost_cnt;
			osc_on_ff   <= nxt_osc_on;
		end
	end

	// -----------------------------------------------------------------
	// ahb-lite slave, zero wait states
	// -----------------------------------------------------------------
	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ph_wr_ff   <= 1'b0;
			ph_addr_ff <= 12'h000;
			HRDATA     <= 32'h0000_0000;
			HREADYOUT  <= 1'b1;
			HRESP      <= 1'b0;
		end else begin
			ph_wr_ff   <= take & HWRITE & addr_ok;
			ph_addr_ff <= HADDR[`CSW_AW-1:0];
			HREADYOUT  <= 1'b1;
			HRESP      <= 1'b0;
			HRDATA     <= 32'h0000_0000;
			if (take && !HWRITE) begin
				case (HADDR[`CSW_AW-1:0])
				`CSW_ADDR_MAIN:
					HRDATA <= {24'h00_0000, 1'b0, cur_ff,
						1'b0, next_ff};
				`CSW_ADDR_SECOND:
					HRDATA <= {24'h00_0000, lock_ff, 1'b0, pll_lock_ff,
						1'b0, fail_ff, 3'h0};
				`CSW_ADDR_CFG:
					HRDATA <= {24'h00_0000, SWITCH_BUSY, CFG_FAIL_SAFE_N,
						CFG_SWITCH_ENABLE_N, 2'h0, CFG_OSC_SEL};
				`CSW_ADDR_DIV:
					HRDATA <= {23'h00_0000, usb_ff, 1'b0, pre_ff,
						2'h0, div_ff};
				default: HRDATA <= 32'h0000_0000;
				endcase
			end
		end
	end

	// -----------------------------------------------------------------
	// clock enables and oscillator controls
	// -----------------------------------------------------------------
	reg  [3:0] pre_m1;
	wire       sys_en, pll_en;

	always @* begin
		case (pre_ff)
		3'h7:    pre_m1 = 4'hB;
		3'h6:    pre_m1 = 4'h7;
		3'h5:    pre_m1 = 4'h5;
		3'h4:    pre_m1 = 4'h4;
		3'h3:    pre_m1 = 4'h3;
		3'h2:    pre_m1 = 4'h2;
		3'h1:    pre_m1 = 4'h1;
		default: pre_m1 = 4'h0;
		endcase
	end

	csw_clk_div #(.W(4)) u_sys_div (
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.period_m1 ((4'h1 << div_ff) - 4'h1),
		.en_ff     (sys_en)
	);

	csw_clk_div #(.W(4)) u_pll_div (
		.clk       (CORE_CLK),
		.rst_n     (RST_N),
		.period_m1 (pre_m1),
		.en_ff     (pll_en)
	);

	always @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			OSC_ENABLE       <= 8'h80;
			SYS_CLK_SEL      <= `CSW_SRC_FAST_RC_POSTSCALED;
			SECONDARY_OSC_ON <= 1'b0;
			SWITCH_BUSY      <= 1'b0;
			SYSCLK_EN        <= 1'b0;
			PLL_IN_EN        <= 1'b0;
		end else begin
			OSC_ENABLE       <= osc_on_ff;
			SYS_CLK_SEL      <= cur_ff;
			SECONDARY_OSC_ON <= (CFG_OSC_SEL == `CSW_SRC_SEC) |
				(next_ff == `CSW_SRC_SEC) | tmr_hold |
				osc_on_ff[`CSW_SRC_SEC];
			SWITCH_BUSY      <= (state_ff != ST_IDLE);
			SYSCLK_EN        <= sys_en;
			PLL_IN_EN        <= pll_en;
		end
	end
endmodule // csw_ctrl

`default_nettype wire

// ---- hdl/csw_defines.vh ----
/*
 * constants of the clock switch controller: register map, field positions,
 * source codes and timing figures.
 * assumes inclusion by the .v files of the block and by the test bench.
 */
`ifndef CSW_DEFINES_VH
`define CSW_DEFINES_VH

// ---------------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------------
`define CSW_ADDR_MAIN      12'h000
`define CSW_ADDR_SECOND    12'h004
`define CSW_ADDR_CFG       12'h008
`define CSW_ADDR_DIV       12'h00C
`define CSW_AW             12

// ---------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------
`define CSW_NEXT_LSB       0
`define CSW_CUR_LSB        4
`define CSW_LOCK_BIT       7
`define CSW_PLLLOCK_BIT    5
`define CSW_FAIL_BIT       3
`define CSW_DIV_LSB        0
`define CSW_PRE_LSB        4
`define CSW_USB_BIT        8

// ---------------------------------------------------------------------
// source codes
// ---------------------------------------------------------------------
`define CSW_SRC_FRC        3'h0
`define CSW_SRC_FAST_RC_WITH_PLL     3'h1
`define CSW_SRC_PRI        3'h2
`define CSW_SRC_PRIPLL     3'h3
`define CSW_SRC_SEC        3'h4
`define CSW_SRC_LOW_POWER_RC       3'h5
`define CSW_SRC_FRC16      3'h6
`define CSW_SRC_FAST_RC_POSTSCALED     3'h7

// ---------------------------------------------------------------------
// timing in ns at 10 ns clock; counts rounded up
// ---------------------------------------------------------------------
`define CSW_CLK_NS         10
`define CSW_LOCK_NS        2000
`define CSW_OST_NS         10240
`define CSW_LOCK_CYC       ((`CSW_LOCK_NS + `CSW_CLK_NS - 1) / `CSW_CLK_NS)
`define CSW_OST_CYC        ((`CSW_OST_NS + `CSW_CLK_NS - 1) / `CSW_CLK_NS)
`define CSW_CNT_W          16
`define CSW_DIV8_CODE      2'h3

`endif

// ---- verif/csw_ctrl_asserts.sv ----
/* port assertions of the clock switch controller.
   assumes binding into csw_ctrl, one clock, reset active low. */
`timescale 1ns/1ns
`default_nettype none
module csw_ctrl_asserts #(
	parameter LOCK_CYC = 4,
	parameter OST_CYC  = 8
) (
	input wire logic       CORE_CLK,
	input wire logic       RST_N,
	input wire logic [2:0] CFG_OSC_SEL,
	input wire logic       CFG_SWITCH_ENABLE_N,
	input wire logic [2:0] TIMER_SECONDARY_OSC_ENABLE,
	input wire logic [7:0] OSC_ENABLE,
	input wire logic [2:0] SYS_CLK_SEL,
	input wire logic       SECONDARY_OSC_ON,
	input wire logic       SWITCH_BUSY
);
// ---------------------------------------------------------------
// switch sequencing
// ---------------------------------------------------------------
default clocking cb @(posedge CORE_CLK); endclocking
default disable iff (!RST_N);
property p_sel_busy;
	$changed(SYS_CLK_SEL) |-> $past(SWITCH_BUSY);
endproperty
a_sel_busy: assert property (p_sel_busy)
	else $error("source changed outside a switch");
property p_new_on;
	$changed(SYS_CLK_SEL) |-> OSC_ENABLE[SYS_CLK_SEL];
endproperty
a_new_on: assert property (p_new_on)
	else $error("new source not running");
property p_old_off;
	$changed(SYS_CLK_SEL) && $past(SYS_CLK_SEL) < 3'h4
		|=> !OSC_ENABLE[$past(SYS_CLK_SEL, 2)];
endproperty
a_old_off: assert property (p_old_off)
	else $error("old source left running");
property p_sec_tmr;
	|TIMER_SECONDARY_OSC_ENABLE |-> ##[0:4] SECONDARY_OSC_ON;
endproperty
a_sec_tmr: assert property (p_sec_tmr)
	else $error("timer enable did not start secondary");
property p_sec_cfg;
	CFG_OSC_SEL == 3'h4 |-> ##[0:3] SECONDARY_OSC_ON;
endproperty
a_sec_cfg: assert property (p_sec_cfg)
	else $error("config did not start secondary");
property p_cfg_dis;
	$fell(SWITCH_BUSY) && CFG_SWITCH_ENABLE_N
		|-> ##[0:1] SYS_CLK_SEL == CFG_OSC_SEL;
endproperty
a_cfg_dis: assert property (p_cfg_dis)
	else $error("disabled switching left non-config source");
property p_busy_bound;
	$rose(SWITCH_BUSY) |-> ##[1:60] !SWITCH_BUSY;
endproperty
a_busy_bound: assert property (p_busy_bound)
	else $error("switch never completed");
property p_pll_wait;
	$changed(SYS_CLK_SEL) && SYS_CLK_SEL == 3'h3 |-> $past(SWITCH_BUSY, 10);
endproperty
a_pll_wait: assert property (p_pll_wait)
	else $error("pll source taken before start-up and lock");
c_pll: cover property ($changed(SYS_CLK_SEL) && SYS_CLK_SEL == 3'h3);
c_dis: cover property ($fell(SWITCH_BUSY) && CFG_SWITCH_ENABLE_N);
c_sec: cover property ($rose(SECONDARY_OSC_ON));
endmodule // csw_ctrl_asserts
bind csw_ctrl csw_ctrl_asserts #(.LOCK_CYC(LOCK_CYC), .OST_CYC(OST_CYC))
	chk_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .CFG_OSC_SEL(CFG_OSC_SEL),
	.CFG_SWITCH_ENABLE_N(CFG_SWITCH_ENABLE_N),
	.TIMER_SECONDARY_OSC_ENABLE(TIMER_SECONDARY_OSC_ENABLE),
	.OSC_ENABLE(OSC_ENABLE), .SYS_CLK_SEL(SYS_CLK_SEL),
	.SECONDARY_OSC_ON(SECONDARY_OSC_ON), .SWITCH_BUSY(SWITCH_BUSY));
`default_nettype wire

// ---- verif/csw_ctrl_test.sv ----
/* self-checking bench of the clock switch controller over ahb-lite.
   assumes csw_ctrl with shortened start-up and lock counts. */
`timescale 1ns/1ns
`default_nettype none
`include "csw_defines.vh"
module csw_ctrl_test;
	logic        CORE_CLK, RST_N, HSEL, HWRITE, fail_req, cfg_sw_n;
	logic [31:0] HADDR, HWDATA, rd, hr_q;
	logic [1:0]  HTRANS;
	logic [2:0]  cfg_sel, tmr_en;
	wire  [31:0] hrdata;
	wire  [7:0]  osc_en;
	wire  [2:0]  sys_sel;
	wire         rdy, resp, sec_on, busy, sys_en, pll_en, fail_ev;
	int          error_cnt, n_tests, k, p;
	int          pre[8] = '{1, 2, 3, 4, 5, 6, 8, 12};
	csw_ctrl #(.LOCK_CYC(4), .OST_CYC(8)) dut_u (
		.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(rdy), .HRDATA(hrdata), .HREADYOUT(rdy), .HRESP(resp),
		.CFG_OSC_SEL(cfg_sel), .CFG_SWITCH_ENABLE_N(cfg_sw_n),
		.CFG_FAIL_SAFE_N(1'b1), .CFG_WATCHDOG_EN(1'b0),
		.TIMER_SECONDARY_OSC_ENABLE(tmr_en), .CLOCK_FAIL_EVENT(fail_ev),
		.OSC_ENABLE(osc_en), .SYS_CLK_SEL(sys_sel),
		.SECONDARY_OSC_ON(sec_on), .SWITCH_BUSY(busy),
		.SYSCLK_EN(sys_en), .PLL_IN_EN(pll_en));
	csw_osc_model osc_u (.clk(CORE_CLK), .osc_en(osc_en), .sel(sys_sel),
		.fail_req(fail_req), .fail_ev(fail_ev));
// ---------------------------------------------------------------
// tasks
// ---------------------------------------------------------------
	initial begin
		CORE_CLK = 1'b0;
		forever #5 CORE_CLK = ~CORE_CLK;
	end
	// read data copy taken just before each edge
	always @(posedge CORE_CLK) hr_q <= hrdata;
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge CORE_CLK);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {20'h0_0000, a};
		@(posedge CORE_CLK);
		while (rdy !== 1'b1) @(posedge CORE_CLK);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		@(posedge CORE_CLK);
		while (rdy !== 1'b1) @(posedge CORE_CLK);
		#1 rd = hr_q;
	endtask
	task automatic idle();
		int j;
		repeat (4) @(posedge CORE_CLK);
		for (j = 0; j < 200 && busy !== 1'b0; j++) @(posedge CORE_CLK);
	endtask
	// cycles between two enable pulses
	task automatic per(input logic s);
		int j;
		p = 0;
		@(posedge CORE_CLK);
		for (j = 0; j < 40 && (s ? pll_en : sys_en) !== 1'b1; j++)
			@(posedge CORE_CLK);
		do begin
			@(posedge CORE_CLK);
			p++;
		end while (p < 40 && (s ? pll_en : sys_en) !== 1'b1);
	endtask
	task automatic rst(input logic [2:0] sel, input logic sw_n);
		@(posedge CORE_CLK);
		RST_N <= 1'b0;
		@(posedge CORE_CLK);
		cfg_sel <= sel;
		cfg_sw_n <= sw_n;
		repeat (20) @(posedge CORE_CLK);
		cmp(sys_sel, 3'h7);
		RST_N <= 1'b1;
	endtask
	task automatic flt();
		@(posedge CORE_CLK);
		fail_req <= 1'b1;
		repeat (6) @(posedge CORE_CLK);
		fail_req <= 1'b0;
		repeat (6) @(posedge CORE_CLK);
	endtask
	task automatic close_out();
		$display("tests=%0d errors=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
// ---------------------------------------------------------------
// tests
// ---------------------------------------------------------------
	initial begin
		{RST_N, HSEL, HWRITE, fail_req, cfg_sw_n} = 5'h00;
		{HADDR, HWDATA, HTRANS, cfg_sel, tmr_en} = 72'h0;
		error_cnt = 0;
		n_tests = 0;
		rst(3'h0, 1'h0);
		idle();
		ahb(0, `CSW_ADDR_MAIN, 0);
		cmp(rd[6:4], 3'h0);
		ahb(0, 12'h010, 0);
		cmp(rd, 32'h0000_0000);
		cmp({rdy, resp}, 2'h2);
		ahb(1, `CSW_ADDR_SECOND, 32'h0000_0080);
		ahb(1, `CSW_ADDR_MAIN, 32'h0000_0003);
		ahb(0, `CSW_ADDR_SECOND, 0);
		cmp(rd[5], 1'h0);
		idle();
		ahb(0, `CSW_ADDR_MAIN, 0);
		cmp(rd[6:4], 3'h3);
		ahb(0, `CSW_ADDR_SECOND, 0);
		cmp(rd[5], 1'h1);
		cmp({osc_en[3], osc_en[0]}, 2'h2);
		for (k = 0; k < 8; k++) begin
			ahb(1, `CSW_ADDR_DIV, {25'h0, k[2:0], 2'h0, k[1:0]});
			per(1);
			per(1);
			cmp(p, pre[k]);
			per(0);
			per(0);
			cmp(p, 1 << k[1:0]);
		end
		ahb(1, `CSW_ADDR_DIV, 32'h0000_0102);
		ahb(1, `CSW_ADDR_DIV, 32'h0000_0103);
		ahb(0, `CSW_ADDR_DIV, 0);
		cmp(rd[1:0], 2'h2);
		ahb(1, `CSW_ADDR_MAIN, 32'h0000_0002);
		ahb(1, `CSW_ADDR_MAIN, 32'h0000_0000);
		idle();
		idle();
		ahb(0, `CSW_ADDR_MAIN, 0);
		cmp(rd[6:4], 3'h0);
		ahb(0, `CSW_ADDR_SECOND, 0);
		cmp({rd[5], osc_en[2]}, 2'h0);
		ahb(1, `CSW_ADDR_MAIN, 32'h0000_0000);
		repeat (3) @(posedge CORE_CLK);
		cmp(busy, 1'h0);
		flt();
		ahb(0, `CSW_ADDR_SECOND, 0);
		cmp(rd[3], 1'h1);
		ahb(1, `CSW_ADDR_SECOND, 32'h0000_0008);
		ahb(0, `CSW_ADDR_SECOND, 0);
		cmp(rd[3], 1'h1);
		ahb(1, `CSW_ADDR_SECOND, 32'h0000_0000);
		ahb(0, `CSW_ADDR_SECOND, 0);
		cmp(rd[3], 1'h0);
		flt();
		ahb(0, `CSW_ADDR_SECOND, 0);
		cmp(rd[3], 1'h1);
		ahb(1, `CSW_ADDR_MAIN, 32'h0000_0002);
		idle();
		ahb(0, `CSW_ADDR_SECOND, 0);
		cmp(rd[3], 1'h0);
		@(posedge CORE_CLK);
		tmr_en <= 3'h2;
		repeat (6) @(posedge CORE_CLK);
		cmp(sec_on, 1'h1);
		tmr_en <= 3'h0;
		repeat (6) @(posedge CORE_CLK);
		cmp(sec_on, 1'h0);
		rst(3'h4, 1'h1);
		idle();
		ahb(0, `CSW_ADDR_MAIN, 0);
		cmp({rd[6:4], sec_on}, 4'h9);
		ahb(0, `CSW_ADDR_CFG, 0);
		cmp(rd, 32'h0000_0064);
		ahb(1, `CSW_ADDR_SECOND, 32'h0000_0080);
		ahb(1, `CSW_ADDR_MAIN, 32'h0000_0000);
		repeat (30) @(posedge CORE_CLK);
		ahb(0, `CSW_ADDR_MAIN, 0);
		cmp(rd[6:4], 3'h4);
		close_out();
	end
	// the tests need under a thousand cycles; this span is 30000 cycles
	initial begin
		#300000;
		error_cnt++;
		close_out();
	end
endmodule // csw_ctrl_test
`default_nettype wire

// ---- verif/csw_osc_model.sv ----
/* oscillator sources seen from the controller: reports a clock failure.
   assumes the bench raises fail_req to make the running source fail. */
`timescale 1ns/1ns
`default_nettype none
module csw_osc_model (
	input wire logic       clk,
	input wire logic [7:0] osc_en,
	input wire logic [2:0] sel,
	input wire logic       fail_req,
	output var logic       fail_ev
);
// ---------------------------------------------------------------
// failure detect
// ---------------------------------------------------------------
	initial fail_ev = 1'b0;
	// only an oscillator that is switched on can fail
	always @(posedge clk) begin
		fail_ev <= fail_req & osc_en[sel];
	end
endmodule // csw_osc_model
`default_nettype wire
